// ==== core/overheat_map.vh ====
// Contract
// [RULE1] Source select 1 uses the motor's built-in sensor and its stored thresholds.
// [RULE2] Motor mode: temperature above warning threshold raises the overheat warning event.
// [RULE3] Motor mode: temperature above alarm threshold raises the overheat alarm event.
// [RULE4] Motor mode: open or shorted thermal input line raises the overheat alarm.
// [RULE5] Motor mode ignores programmable alarm, warning and filter settings.
// [RULE6] Select 2 monitors negative machine voltage, select 3 positive machine voltage.
// [RULE7] Alarm voltage threshold 0 to 500 in 0.01 V, default 250, immediate.
// [RULE8] Warning threshold 0 to 100 percent, default 100, immediate.
// [RULE9] Alarm filter time 0 to 65535 seconds, default 0, immediate.
// [RULE10] Outside circuit should present negative voltage so line faults stay detectable.
// [RULE11] Negative machine mode alarms on line fault; positive machine mode does not.
// [RULE12] Warning is percent of alarm level; alarm only after filter time persists.
`ifndef OVERHEAT_MAP_VH
`define OVERHEAT_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OH_ADDR_SELECT 4'h0
`define OH_ADDR_ALARM_LVL 4'h1
`define OH_ADDR_WARN_PCT 4'h2
`define OH_ADDR_FILTER 4'h3
`define OH_ADDR_STATUS 4'h4
`define OH_ADDR_MASK 4'h5
`define OH_ADDR_LIVE 4'h6
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define OH_SELECT_RST 2'h0
`define OH_ALARM_LVL_RST 16'h00fa
`define OH_WARN_PCT_RST 16'h0064
`define OH_FILTER_RST 16'h0000
`define OH_ALARM_LVL_MAX 16'h01f4
`define OH_WARN_PCT_MAX 16'h0064
`define OH_MASK_RST 3'h0
// ----------------------------------------
// Source select codes
// ----------------------------------------
`define OH_SEL_OFF 2'h0
`define OH_SEL_MOTOR 2'h1
`define OH_SEL_NEG 2'h2
`define OH_SEL_POS 2'h3
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define OH_BIT_WARN 0
`define OH_BIT_ALARM 1
`define OH_BIT_FAULT 2
// ----------------------------------------
// Timing and percent scale
// ----------------------------------------
`define OH_CLK_HZ 125000000
`define OH_PCT_FULL 100
`endif

// ==== core/overheat_protection_monitor.v ====
`timescale 1ns/1ps
`default_nettype none
`include "overheat_map.vh"
module overheat_protection_monitor #(
	parameter integer TICKS_PER_SEC = `OH_CLK_HZ
) (
	input wire clk_sys,
	input wire rst_n,
	input wire [3:0] regAddr,
	input wire [15:0] regWrData,
	input wire regWrite,
	input wire regRead,
	output reg [15:0] regRdData,
	input wire [15:0] thermalInput,
	input wire lineFaultIn,
	input wire motorWarnIn,
	input wire motorAlarmIn,
	output reg overheatWarningEvent,
	output reg overheatAlarmEvent,
	output wire irq
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [15:0] thermMeta_q, thermSync_q;
	reg [2:0] pinMeta_q, pinSync_q;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			thermMeta_q <= 16'h0000;
			thermSync_q <= 16'h0000;
			pinMeta_q <= 3'h0;
			pinSync_q <= 3'h0;
		end else begin
			thermMeta_q <= thermalInput;
			thermSync_q <= thermMeta_q;
			pinMeta_q <= {motorAlarmIn, motorWarnIn, lineFaultIn};
			pinSync_q <= pinMeta_q;
		end
	end
	wire faultS = pinSync_q[0];
	wire motorWarnS = pinSync_q[1];
	wire motorAlarmS = pinSync_q[2];
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [1:0] select_q;
	reg [15:0] alarmLevel_q, warnPct_q, filterSec_q;
	reg [2:0] status_q, mask_q;
	function [15:0] clampTo;
		input [15:0] v;
		input [15:0] lim;
		begin
			clampTo = (v > lim) ? lim : v;
		end
	endfunction
	wire wrHit = regWrite;
	reg [2:0] events;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			select_q <= `OH_SELECT_RST;
			alarmLevel_q <= `OH_ALARM_LVL_RST; // [RULE7]
			warnPct_q <= `OH_WARN_PCT_RST; // [RULE8]
			filterSec_q <= `OH_FILTER_RST; // [RULE9]
			mask_q <= `OH_MASK_RST;
		end else if (wrHit) begin
			case (regAddr)
				`OH_ADDR_SELECT: select_q <= regWrData[1:0];
				`OH_ADDR_ALARM_LVL: alarmLevel_q <= clampTo(regWrData, `OH_ALARM_LVL_MAX); // [RULE7]
				`OH_ADDR_WARN_PCT: warnPct_q <= clampTo(regWrData, `OH_WARN_PCT_MAX); // [RULE8]
				`OH_ADDR_FILTER: filterSec_q <= regWrData; // [RULE9]
				`OH_ADDR_MASK: mask_q <= regWrData[2:0];
				default: begin
				end
			endcase
		end
	end
	// ----------------------------------------
	// Machine sensing
	// ----------------------------------------
	// Input is signed hundredths of a volt; negative mode flips it
	wire signed [16:0] thermSigned = {thermSync_q[15], thermSync_q};
	wire signed [16:0] magnitude = (select_q == `OH_SEL_NEG) ? -thermSigned : thermSigned; // [RULE6]
	// Warning level as percent of alarm level, compared without dividing
	wire [31:0] warnScaled = alarmLevel_q * warnPct_q; // [RULE12]
	wire [31:0] magScaled = {15'h0000, magnitude} * `OH_PCT_FULL;
	wire magPos = !magnitude[16];
	wire machWarn = magPos && (magScaled >= warnScaled); // [RULE12]
	wire machOver = magPos && ({15'h0000, magnitude} >= {16'h0000, alarmLevel_q});
	wire machMode = (select_q == `OH_SEL_NEG) || (select_q == `OH_SEL_POS); // [RULE6]
	wire motorMode = (select_q == `OH_SEL_MOTOR); // [RULE1]
	// Positive mode can't tell a fault from a cold sensor
	wire faultAlarm = faultS && (motorMode || select_q == `OH_SEL_NEG); // [RULE4] [RULE11]
	// ----------------------------------------
	// Alarm filter
	// ----------------------------------------
	reg [31:0] tick_q;
	reg [15:0] secs_q;
	wire filterDone = (secs_q >= filterSec_q); // [RULE12]
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 32'h0;
			secs_q <= 16'h0;
		end else if (!(machMode && machOver)) begin
			tick_q <= 32'h0;
			secs_q <= 16'h0;
		end else if (!filterDone) begin
			if (tick_q == TICKS_PER_SEC - 1) begin
				tick_q <= 32'h0;
				secs_q <= secs_q + 16'h0001; // [RULE9]
			end else begin
				tick_q <= tick_q + 32'h1;
			end
		end
	end
	// ----------------------------------------
	// Events
	// ----------------------------------------
	wire warnNow = motorMode ? motorWarnS : (machMode && machWarn); // [RULE2] [RULE5]
	wire alarmNow = motorMode ? (motorAlarmS || faultAlarm) : // [RULE3] [RULE4] [RULE5]
		(machMode && ((machOver && filterDone) || faultAlarm)); // [RULE11] [RULE12]
	always @* begin
		events = 3'h0;
		events[`OH_BIT_WARN] = warnNow;
		events[`OH_BIT_ALARM] = alarmNow;
		events[`OH_BIT_FAULT] = faultAlarm;
	end
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			overheatWarningEvent <= 1'b0;
			overheatAlarmEvent <= 1'b0;
			status_q <= 3'h0;
		end else begin
			overheatWarningEvent <= warnNow;
			overheatAlarmEvent <= alarmNow;
			// Set wins over write-one-to-clear
			if (wrHit && regAddr == `OH_ADDR_STATUS) begin
				status_q <= (status_q & ~regWrData[2:0]) | events;
			end else begin
				status_q <= status_q | events;
			end
		end
	end
	assign irq = |(status_q & mask_q);
	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= 16'h0000;
		end else if (regRead) begin
			case (regAddr)
				`OH_ADDR_SELECT: regRdData <= {14'h0000, select_q};
				`OH_ADDR_ALARM_LVL: regRdData <= alarmLevel_q;
				`OH_ADDR_WARN_PCT: regRdData <= warnPct_q;
				`OH_ADDR_FILTER: regRdData <= filterSec_q;
				`OH_ADDR_STATUS: regRdData <= {13'h0000, status_q};
				`OH_ADDR_MASK: regRdData <= {13'h0000, mask_q};
				`OH_ADDR_LIVE: regRdData <= {13'h0000, faultAlarm, alarmNow, warnNow};
				default: regRdData <= 16'h0000;
			endcase
		end else begin
			regRdData <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// ==== verification/overheat_monitor_checker_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module overheat_monitor_checker (
	input wire clk_sys,
	input wire rst_n,
	input wire [3:0] regAddr,
	input wire [15:0] regWrData,
	input wire regWrite,
	input wire regRead,
	input wire [15:0] regRdData,
	input wire [15:0] thermalInput,
	input wire lineFaultIn,
	input wire motorWarnIn,
	input wire motorAlarmIn,
	input wire overheatWarningEvent,
	input wire overheatAlarmEvent,
	input wire irq
);
	logic [1:0] selQ;
	logic filtZeroQ;
	// Shadow copies, so mode checks need no look inside
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			selQ <= 2'h0;
			filtZeroQ <= 1'b1;
		end else if (regWrite && regAddr == 4'h0) begin
			selQ <= regWrData[1:0];
		end else if (regWrite && regAddr == 4'h3) begin
			filtZeroQ <= regWrData == 16'h0000;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	chk_read_idle: assert property (!$past(regRead) |-> regRdData == 16'h0000) else $error("read data off slot");
	chk_off_silent: assert property ((selQ == 2'h0) [*5] |-> !overheatAlarmEvent && !overheatWarningEvent)
		else $error("event while off");
	chk_motor_alarm: assert property ((selQ == 2'h1 && motorAlarmIn) [*5] |-> overheatAlarmEvent)
		else $error("motor alarm lost");
	chk_motor_warn: assert property ((selQ == 2'h1 && motorWarnIn) [*5] |-> overheatWarningEvent)
		else $error("motor warning lost");
	chk_motor_fault: assert property ((selQ == 2'h1 && lineFaultIn) [*5] |-> overheatAlarmEvent)
		else $error("motor line fault lost");
	chk_motor_quiet: assert property ((selQ == 2'h1 && !motorAlarmIn && !lineFaultIn) [*5] |-> !overheatAlarmEvent)
		else $error("motor alarm from settings");
	chk_neg_fault: assert property ((selQ == 2'h2 && filtZeroQ && lineFaultIn) [*5] |-> overheatAlarmEvent)
		else $error("negative mode fault lost");
	chk_pos_fault: assert property ((selQ == 2'h3 && lineFaultIn && thermalInput[15]) [*5] |-> !overheatAlarmEvent)
		else $error("positive mode fault alarm");
	cover property (overheatAlarmEvent && selQ == 2'h2);
	cover property (overheatWarningEvent && selQ == 2'h3);
	cover property (irq);
endmodule
bind overheat_protection_monitor overheat_monitor_checker i_chk (.*);
`default_nettype wire

// ==== verification/thermal_sensor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module thermal_sensor_model (
	input wire logic clk_sys,
	output logic [15:0] thermalInput,
	output logic lineFaultIn,
	output logic motorWarnIn,
	output logic motorAlarmIn
);
	initial {thermalInput, lineFaultIn, motorAlarmIn, motorWarnIn} = '0;
	// Pins hold long enough to clear the synchroniser
	task automatic drive(input logic [15:0] v, input logic [2:0] f);
		@(posedge clk_sys);
		thermalInput <= v;
		{lineFaultIn, motorAlarmIn, motorWarnIn} <= f;
		repeat (6) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ==== verification/overheat_protection_monitor_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checkCount++; if ((a) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module overheat_protection_monitor_tb_top;
	logic clk_sys = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000, regRdData, thermalInput, v;
	logic lineFaultIn, motorWarnIn, motorAlarmIn, overheatWarningEvent, overheatAlarmEvent, irq;
	logic [2:0] f;
	logic [15:0] rv[8] = '{16'h0000, 16'h00fa, 16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	int miscompares = 0, checkCount = 0, cycles = 0, lvl = 0, pct = 0;
	always #4 clk_sys = ~clk_sys;
	overheat_protection_monitor #(.TICKS_PER_SEC(10)) i_dut (.*);
	thermal_sensor_model i_sensor (.*);
	// ----
	// Bus tasks and expectations
	// ----
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		{regAddr, regWrData, regWrite} <= {a, d, 1'b1};
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask
	task automatic rdChk(input logic [3:0] a, input logic [15:0] x);
		@(posedge clk_sys);
		{regAddr, regRead} <= {a, 1'b1};
		@(posedge clk_sys);
		regRead <= 1'b0;
		@(negedge clk_sys);
		`CHK("read", x, regRdData)
	endtask
	function automatic logic [1:0] expEv(input int s, input logic [15:0] t, input logic [2:0] p);
		int m;
		m = (s == 2) ? -int'($signed(t)) : int'($signed(t));
		if (s == 1) return {p[2] | p[1], p[0]};
		if (s == 0) return 2'h0;
		return {m >= lvl || (s == 2 && p[2]), m * 100 >= lvl * pct};
	endfunction
	task automatic stim(input int s, input logic [15:0] t, input logic [2:0] p);
		i_sensor.drive(t, p);
		@(negedge clk_sys);
		`CHK("alarm", expEv(s, t, p) >> 1, overheatAlarmEvent)
		`CHK("warn", expEv(s, t, p) & 2'h1, overheatWarningEvent)
	endtask
	task automatic endOfTest();
		$display("checks %0d miscompares %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			endOfTest();
		end
	end
	initial begin
		void'($urandom(91));
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		foreach (rv[i]) rdChk(4'(i), rv[i]);
		wr(4'h1, 16'h0258);
		rdChk(4'h1, 16'h01f4);
		wr(4'h2, 16'h0096);
		rdChk(4'h2, 16'h0064);
		wr(4'h3, 16'hffff);
		rdChk(4'h3, 16'hffff);
		wr(4'h3, 16'h0000);
		wr(4'h1, 16'h0000);
		wr(4'h2, 16'h0000);
		wr(4'h0, 16'h0001);
		for (int k = 0; k < 8; k++) stim(1, 16'h01f4, 3'(k));
		rdChk(4'h4, 16'h0007);
		`CHK("irq", 1'b0, irq)
		wr(4'h5, 16'h0002);
		@(negedge clk_sys);
		`CHK("irq", 1'b1, irq)
		stim(1, 16'h0000, 3'h0);
		wr(4'h4, 16'h0007);
		@(negedge clk_sys);
		`CHK("irq", 1'b0, irq)
		for (int s = 0; s < 4; s++) if (s != 1) begin
			lvl = $urandom_range(500);
			pct = $urandom_range(100);
			wr(4'h1, 16'(lvl));
			wr(4'h2, 16'(pct));
			wr(4'h0, 16'(s));
			stim(s, (s == 2) ? 16'(-lvl) : 16'(lvl), 3'h0);
			repeat (12) begin
				v = 16'($urandom_range(1200)) - 16'h0258;
				f = 3'($urandom);
				stim(s, v, f);
			end
		end
		wr(4'h0, 16'h0002);
		i_sensor.drive(16'h0000, 3'h4);
		@(negedge clk_sys);
		`CHK("alarm", 1'b1, overheatAlarmEvent)
		wr(4'h1, 16'h0064);
		wr(4'h3, 16'h0001);
		i_sensor.drive(16'h0000, 3'h0);
		// Over the level but filter still counting; warning has no filter
		i_sensor.drive(16'hff9c, 3'h0);
		@(negedge clk_sys);
		`CHK("alarm", 1'b0, overheatAlarmEvent)
		`CHK("warn", 1'b1, overheatWarningEvent)
		repeat (12) @(negedge clk_sys);
		`CHK("alarm", 1'b1, overheatAlarmEvent)
		endOfTest();
	end
endmodule
`default_nettype wire
